// ### rtl/mist_irq_ctrl.sv
// interrupt request flags, enables, priority vectoring and dual time-base dividers
// assumes the core acks a vector with a pulse and reports a full return stack
// Operation
// - ext pin flag set on selected edge
// - vector needs global, source enable, stack room
// - ext service clears flag and global enable
// - edge select: off, rise, fall, both
// - pull-high kept while pin is interrupt
// - comparator flag set on output toggle
// - conversion done sets converter flag
// - time-base flag set on divider overflow
// - prescaler source: sys, sys/4, sub clock
// - time base 0 run bit, period 2^8..2^15
// - time base 1 same as base 0
// - serial module flag on byte, address, timeout
// - supply monitor low sets low supply flag
// - eeprom write end sets its flag
// - uart request from any uart condition
// - uart service clears only request, global
// - group flag set by any member flag rising
// - group service leaves member flags set
// - group vectors only with group enable
// - any flag rising makes wake-up pulse
// - return-from-irq sets global, plain return not
module mist_irq_ctrl #(
  parameter int NUM_GROUPS = 2
) (
  input wire logic i_clk, // 200 MHz system clock
  input wire logic i_rst_n, // async active-low reset
  input wire logic [4:0] i_avs_address, // word address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte lanes
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // stall
  input wire logic [1:0] i_ext_irq_pins, // external interrupt pins
  input wire logic [1:0] i_ext_pin_pull_sel, // pull-high selection from port logic
  output logic [1:0] o_ext_pin_pull_en, // pull-high drive to pad
  input wire logic [1:0] i_comparator_out, // comparator outputs
  input wire logic i_conv_done, // a/d conversion finished pulse
  input wire logic i_sub_clk_tick, // sub clock tick, one cycle
  input wire logic [3:0] i_serial_module_events, // byte rx, byte tx, addr match, timeout
  input wire logic i_supply_monitor_low, // low supply level
  input wire logic i_eeprom_write_end, // write cycle end pulse
  input wire logic [5:0] i_async_serial_events, // uart conditions
  input wire logic [2*NUM_GROUPS-1:0] i_member_flags, // timer-module flags, two per group
  input wire logic i_stack_full, // return stack full
  input wire logic i_vector_ack, // core took the vector
  input wire logic i_return_from_irq, // return_from_irq executed
  output logic o_irq_req, // vector request to core
  output logic [3:0] o_irq_vector, // selected source index
  output logic o_wake // wake-up pulse
);
  localparam int NS = mist_pkg::NUM_SRC;
  initial begin
    if (NUM_GROUPS < 1 || NUM_GROUPS > 4) $error("NUM_GROUPS must be 1..4");
    if (mist_pkg::SRC_MF0 + NUM_GROUPS > NS) $error("group sources exceed the flag vector");
  end

  typedef struct packed {
    logic glb;
    logic [NS-1:0] en;
    logic [NS-1:0] flg;
    logic [3:0] edge_sel;
    logic [1:0] psc_src;
    logic [7:0] tb0;
    logic [7:0] tb1;
    logic [1:0] cmp_prev;
    logic [2*NUM_GROUPS-1:0] mem_prev;
    logic [1:0] psc_div;
    logic [31:0] rdata;
    logic wait_n;
    logic irq;
    logic [3:0] vec;
    logic wake;
    logic [1:0] pull;
    mist_pkg::bus_state_e st;
  } mist_state_s;

  mist_state_s s_q, s_d;
  logic rst_n_sync;
  logic rs1_q, rs2_q;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_n_sync = rs2_q;

  logic [NS-1:0] set_v;
  logic [NS-1:0] pend;
  logic psc_tick;
  logic wr_acc;
  logic [7:0] badr;
  logic [3:0] pick;
  logic found;
  logic [NS-1:0] svc_clr;
  logic [1:0] pin_hit;
  logic tb0_over;
  logic tb1_over;

  // one detector per external pin; each keeps its own last level
  for (genvar p = 0; p < 2; p++) begin : g_pin
    mist_pin_edge i_mist_pin_edge (
      .i_clk(i_clk),
      .i_rst_n(rst_n_sync),
      .i_pin(i_ext_irq_pins[p]),
      .i_sel(s_q.edge_sel[2*p +: 2]),
      .o_hit(pin_hit[p])
    );
  end

  // both time bases share the prescaled tick
  mist_interval_div #(
    .DIV_W(mist_pkg::TB_DIV_W),
    .BASE_EXP(mist_pkg::TB_BASE_EXP)
  ) i_mist_interval_div0 (
    .i_clk(i_clk),
    .i_rst_n(rst_n_sync),
    .i_run(s_q.tb0[mist_pkg::TB_RUN_BIT]),
    .i_period(s_q.tb0[mist_pkg::TB_PER_LSB +: 3]),
    .i_tick(psc_tick),
    .o_over(tb0_over)
  );
  mist_interval_div #(
    .DIV_W(mist_pkg::TB_DIV_W),
    .BASE_EXP(mist_pkg::TB_BASE_EXP)
  ) i_mist_interval_div1 (
    .i_clk(i_clk),
    .i_rst_n(rst_n_sync),
    .i_run(s_q.tb1[mist_pkg::TB_RUN_BIT]),
    .i_period(s_q.tb1[mist_pkg::TB_PER_LSB +: 3]),
    .i_tick(psc_tick),
    .o_over(tb1_over)
  );

  // prescaler source select; kept apart so the dividers see no loop through the main block
  always_comb begin
    case (s_q.psc_src)
      mist_pkg::PSC_SYS: psc_tick = 1'b1;
      mist_pkg::PSC_SYS4: psc_tick = (s_q.psc_div == 2'h3);
      default: psc_tick = i_sub_clk_tick;
    endcase
  end

  always_comb begin
    s_d = s_q;
    set_v = '0;
    svc_clr = '0;
    pick = 4'h0;
    found = 1'b0;
    badr = {1'b0, i_avs_address, 2'b00};
    wr_acc = i_avs_write && s_q.wait_n;

    s_d.cmp_prev = i_comparator_out;
    s_d.mem_prev = i_member_flags;
    s_d.pull = i_ext_pin_pull_sel; // pull-high stays valid

    // event detection
    for (int p = 0; p < 2; p++) begin
      set_v[mist_pkg::SRC_EXT0 + p] = pin_hit[p];
      set_v[mist_pkg::SRC_CMP0 + p] = s_q.cmp_prev[p] ^ i_comparator_out[p];
    end
    set_v[mist_pkg::SRC_ADC] = i_conv_done;
    set_v[mist_pkg::SRC_SIM] = |i_serial_module_events;
    set_v[mist_pkg::SRC_LVD] = i_supply_monitor_low;
    set_v[mist_pkg::SRC_EE] = i_eeprom_write_end;
    set_v[mist_pkg::SRC_UART] = |i_async_serial_events;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      set_v[mist_pkg::SRC_MF0 + g] = |(i_member_flags[2*g +: 2] & ~s_q.mem_prev[2*g +: 2]);
    end

    // free-running phase for the sys/4 source; its phase is not tied to the select write
    s_d.psc_div = s_q.psc_div + 2'h1;

    // one flag per divider period
    set_v[mist_pkg::SRC_TB0] = tb0_over;
    set_v[mist_pkg::SRC_TB1] = tb1_over;

    // priority pick among enabled pending sources
    pend = s_q.flg & s_q.en;
    for (int k = NS - 1; k >= 0; k--) begin
      if (pend[k]) begin
        pick = 4'(k);
        found = 1'b1;
      end
    end
    // vector only with global enable and stack room
    s_d.irq = s_q.glb && found && !i_stack_full && !i_vector_ack;
    s_d.vec = pick;

    // service: clear only the serviced flag and the global enable
    if (i_vector_ack && s_q.irq) begin
      svc_clr[s_q.vec] = 1'b1;
      s_d.glb = 1'b0;
    end
    if (i_return_from_irq) s_d.glb = 1'b1;

    // register writes; hardware set wins over any clear
    if (wr_acc) begin
      case (badr)
        mist_pkg::ADDR_GLOBAL: begin
          // a software write here wins over a service clear in the same cycle
          if (i_avs_byteenable[0]) begin
            s_d.glb = i_avs_writedata[mist_pkg::GLB_EN_BIT];
          end
        end
        mist_pkg::ADDR_ENABLE: s_d.en = i_avs_writedata[NS-1:0];
        mist_pkg::ADDR_FLAGS: s_d.flg = s_q.flg & ~i_avs_writedata[NS-1:0];
        mist_pkg::ADDR_EDGE: begin
          if (i_avs_byteenable[0]) begin
            s_d.edge_sel = i_avs_writedata[3:0];
          end
        end
        mist_pkg::ADDR_PSC: begin
          if (i_avs_byteenable[0]) begin
            s_d.psc_src = i_avs_writedata[mist_pkg::PSC_SRC_LSB +: 2];
          end
        end
        mist_pkg::ADDR_TB0: begin
          // unimplemented bits 6..3 are dropped so they read back as zero
          if (i_avs_byteenable[0]) begin
            s_d.tb0 = i_avs_writedata[7:0] & 8'h87;
          end
        end
        mist_pkg::ADDR_TB1: begin
          if (i_avs_byteenable[0]) begin
            s_d.tb1 = i_avs_writedata[7:0] & 8'h87;
          end
        end
        default: ;
      endcase
    end
    s_d.flg = (s_d.flg & ~svc_clr) | set_v;
    s_d.wake = |(set_v & ~s_q.flg);

    // one wait state per access, read data registered
    if (i_avs_read || i_avs_write) begin
      s_d.wait_n = !s_q.wait_n;
    end else begin
      s_d.wait_n = 1'b0;
    end
    if (i_avs_read && !s_q.wait_n) begin
      case (badr)
        mist_pkg::ADDR_GLOBAL: s_d.rdata = {31'h0, s_q.glb};
        mist_pkg::ADDR_ENABLE: s_d.rdata = {17'h0, s_q.en};
        mist_pkg::ADDR_FLAGS: s_d.rdata = {17'h0, s_q.flg};
        mist_pkg::ADDR_EDGE: s_d.rdata = {28'h0, s_q.edge_sel};
        mist_pkg::ADDR_PSC: s_d.rdata = {30'h0, s_q.psc_src};
        mist_pkg::ADDR_TB0: s_d.rdata = {24'h0, s_q.tb0};
        mist_pkg::ADDR_TB1: s_d.rdata = {24'h0, s_q.tb1};
        mist_pkg::ADDR_MEMBER: s_d.rdata = 32'(i_member_flags);
        mist_pkg::ADDR_WAKE: s_d.rdata = {30'h0, s_q.irq, s_q.wake};
        default: s_d.rdata = mist_pkg::UNMAPPED_RD;
      endcase
    end
    s_d.st = s_d.irq ? mist_pkg::ST_VECT : mist_pkg::ST_IDLE;
  end

  always_ff @(posedge i_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_q <= '0;
      s_q.edge_sel <= mist_pkg::EDGE_RST;
      s_q.psc_src <= mist_pkg::PSC_RST[1:0];
      s_q.tb0 <= mist_pkg::TB_RST;
      s_q.tb1 <= mist_pkg::TB_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // software must enable, route and set input direction first
  assign o_avs_readdata = s_q.rdata;
  assign o_avs_waitrequest = !s_q.wait_n;
  assign o_ext_pin_pull_en = s_q.pull;
  assign o_irq_req = s_q.irq;
  assign o_irq_vector = s_q.vec;
  assign o_wake = s_q.wake;
endmodule

// edge detector for one interrupt pin with a selectable trigger
module mist_pin_edge (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // synchronised active-low reset
  input wire logic i_pin, // pin level, synchronous
  input wire logic [1:0] i_sel, // trigger select: off, rise, fall, both
  output logic o_hit // selected edge seen this cycle
);
  typedef struct packed {
    logic prev;
  } mist_edge_state_s;

  mist_edge_state_s s_q, s_d;
  logic rise;
  logic fall;

  always_comb begin
    s_d = s_q;
    s_d.prev = i_pin;
    rise = !s_q.prev && i_pin;
    fall = s_q.prev && !i_pin;
    case (i_sel)
      mist_pkg::EDGE_RISE: o_hit = rise;
      mist_pkg::EDGE_FALL: o_hit = fall;
      mist_pkg::EDGE_BOTH: o_hit = rise || fall;
      default: o_hit = 1'b0; // off code turns the pin function off
    endcase
  end

  // last level clears to low, the idle level of an unused pin; a pin
  // held high through reset therefore reads as one rising edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// one interval divider: counts prescaled ticks, marks the last tick of each period
module mist_interval_div #(
  parameter int DIV_W = 16, // counter width
  parameter int BASE_EXP = 8 // exponent of the shortest period
) (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // synchronised active-low reset
  input wire logic i_run, // divider enable
  input wire logic [2:0] i_period, // period select, 2^(BASE_EXP+n) ticks
  input wire logic i_tick, // prescaled tick
  output logic o_over // last tick of a period, combinational
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } mist_div_state_s;

  mist_div_state_s s_q, s_d;
  logic [DIV_W-1:0] mask;

  initial begin
    if (BASE_EXP < 1 || BASE_EXP + 7 > DIV_W) $error("DIV_W too small for the longest period");
  end

  always_comb begin
    s_d = s_q;
    o_over = 1'b0;
    // low BASE_EXP+n bits all ones marks the final tick of a period
    mask = {DIV_W{1'b1}} >> (DIV_W - BASE_EXP - int'(i_period));
    // a stopped divider restarts from zero, so the first period after enable is whole
    if (!i_run) begin
      s_d.cnt = '0;
    end else if (i_tick) begin
      s_d.cnt = s_q.cnt + DIV_W'(1);
      o_over = ((s_q.cnt & mask) == mask);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ### shared/mist_pkg.sv
// package for the interrupt source and time-base block: register map, fields, resets, codes
// assumes an avalon-mm slave with 32-bit data, one register per aligned word
package mist_pkg;
  localparam int NUM_SRC = 15;
  // register byte addresses
  localparam logic [7:0] ADDR_GLOBAL = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_EDGE = 8'h0C;
  localparam logic [7:0] ADDR_PSC = 8'h10;
  localparam logic [7:0] ADDR_TB0 = 8'h14;
  localparam logic [7:0] ADDR_TB1 = 8'h18;
  localparam logic [7:0] ADDR_MEMBER = 8'h1C;
  localparam logic [7:0] ADDR_WAKE = 8'h20;
  // source index, fixed priority: lower index wins
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_CMP0 = 2;
  localparam int SRC_CMP1 = 3;
  localparam int SRC_ADC = 4;
  localparam int SRC_TB0 = 5;
  localparam int SRC_TB1 = 6;
  localparam int SRC_SIM = 7;
  localparam int SRC_LVD = 8;
  localparam int SRC_EE = 9;
  localparam int SRC_UART = 10;
  localparam int SRC_MF0 = 11;
  localparam int SRC_MF1 = 12;
  localparam int SRC_MF2 = 13;
  localparam int SRC_MF3 = 14;
  // field positions
  localparam int TB_RUN_BIT = 7;
  localparam int TB_PER_LSB = 0;
  localparam int PSC_SRC_LSB = 0;
  localparam int GLB_EN_BIT = 0;
  localparam int MEMBER_BITS = 8;
  // reset values
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam logic [7:0] TB_RST = 8'h00;
  localparam logic [3:0] EDGE_RST = 4'h0;
  // edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // prescaler source codes
  localparam logic [1:0] PSC_SYS = 2'h0;
  localparam logic [1:0] PSC_SYS4 = 2'h1;
  localparam int TB_BASE_EXP = 8;
  localparam int TB_DIV_W = 16;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_VECT = 2'b01
  } bus_state_e;
endpackage

// ### tb/mist_core_model.sv
// core stand-in: takes vectors, ends each service after a short routine
// assumes the clock of the irq block
module mist_core_model (
  input wire logic i_clk, // clock
  input wire logic i_irq_req, // vector request
  input wire logic [3:0] i_irq_vector, // requested source
  input wire logic i_use_return_from_irq, // end with return_from_irq
  output logic o_vector_ack, // vector taken
  output logic o_return_from_irq, // return pulse
  output logic o_taken, // one-cycle taken mark
  output logic [3:0] o_taken_vec // source taken
);
  timeunit 1ns;
  timeprecision 100ps;
  logic slow = 0;
  initial begin
    {o_vector_ack, o_return_from_irq, o_taken, o_taken_vec} = '0;
    forever begin
      @(posedge i_clk);
      if (i_irq_req) begin
        slow = ~slow;
        // alternate prompt and slow answers
        repeat (slow ? 3 : 0) @(posedge i_clk);
        o_vector_ack <= 1;
        @(posedge i_clk);
        o_vector_ack <= 0;
        o_taken <= 1;
        o_taken_vec <= i_irq_vector;
        @(posedge i_clk);
        o_taken <= 0;
        repeat (4) @(posedge i_clk);
        o_return_from_irq <= i_use_return_from_irq;
        @(posedge i_clk);
        o_return_from_irq <= 0;
      end
    end
  end
endmodule

// ### tb/mist_irq_ctrl_properties.sv
// port checker for the irq block
// assumes one clock domain; bound onto every instance
module mist_irq_ctrl_properties #(
  parameter int NUM_GROUPS = 2
) (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // reset
  input wire logic [4:0] i_avs_address, // address
  input wire logic i_avs_read, // read
  input wire logic i_avs_write, // write
  input wire logic [31:0] o_avs_readdata, // read data
  input wire logic o_avs_waitrequest, // stall
  input wire logic [1:0] i_ext_pin_pull_sel, // pull select
  input wire logic [1:0] o_ext_pin_pull_en, // pull drive
  input wire logic i_stack_full, // stack full
  input wire logic i_vector_ack, // ack
  input wire logic o_irq_req, // request
  input wire logic [3:0] o_irq_vector // vector
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_bus;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_served;
    o_irq_req && i_vector_ack;
  endsequence
  sequence s_rd_done;
    i_avs_read && !o_avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_bus |=> !o_avs_waitrequest)
    else $error("bus not answered");
  a_answer_once: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer held");
  a_stack_block: assert property (i_stack_full && $past(i_stack_full) |-> !o_irq_req)
    else $error("request while stack full");
  a_ack_drop: assert property (s_served |-> ##[1:2] !o_irq_req)
    else $error("request kept after ack");
  a_served_quiet: assert property (s_served |-> ##2 (!o_irq_req) [*2])
    else $error("request without global enable");
  a_vec_range: assert property (o_irq_req |-> int'(o_irq_vector) < 11 + NUM_GROUPS)
    else $error("vector out of range");
  a_pull_copy: assert property ($past(i_rst_n, 4) |->
    o_ext_pin_pull_en == $past(i_ext_pin_pull_sel))
    else $error("pull-high lost");
  a_psc_pad: assert property (s_rd_done ##0 i_avs_address == 5'h04 |->
    o_avs_readdata[31:2] == 0)
    else $error("prescaler pad bits set");
  a_tb_pad: assert property (s_rd_done ##0 i_avs_address inside {5'h05, 5'h06} |->
    (o_avs_readdata & ~32'h87) == 0)
    else $error("time base pad bits set");
  a_unmapped: assert property (s_rd_done ##0 i_avs_address > 5'h08 |->
    o_avs_readdata == mist_pkg::UNMAPPED_RD)
    else $error("unmapped read not zero");
endmodule
bind mist_irq_ctrl mist_irq_ctrl_properties #(.NUM_GROUPS(NUM_GROUPS)) i_props (
  .i_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .i_ext_pin_pull_sel, .o_ext_pin_pull_en, .i_stack_full,
  .i_vector_ack, .o_irq_req, .o_irq_vector);

// ### tb/tb_top.sv
// self-checking bench for the irq block
// assumes the core stand-in in mist_core_model.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 0, i_rst_n = 0, rd = 0, wr = 0, cv = 0, supply_monitor = 0, ee = 0, sub = 0, stk = 0;
  logic return_from_irq = 1, irq_d = 0, wait_r, ack, ret, irq, wake, taken;
  logic [4:0] addr = 0;
  logic [7:0] a;
  logic [31:0] wd = 0, rdata, r;
  logic [1:0] pins = 0, pull = 0, cmp = 0, pull_en;
  logic [3:0] sim = 0, mem = 0, vec, tvec;
  logic [5:0] uart = 0;
  logic [63:0] q[$];
  logic [3:0] vq[$];
  int seed = 22, n_errors = 0, total_checks = 0, cyc = 0, nwake = 0, nrise = 0;
  int t0 = 0, t1 = 0, w;
  int ps[4] = '{0, 1, 3, 0};
  int per[4] = '{256, 1024, 2048, 512};
  mist_irq_ctrl #(.NUM_GROUPS(2)) i_mist_irq_ctrl (
    .i_clk, .i_rst_n, .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .i_ext_irq_pins(pins), .i_ext_pin_pull_sel(pull),
    .o_ext_pin_pull_en(pull_en), .i_comparator_out(cmp), .i_conv_done(cv),
    .i_sub_clk_tick(sub), .i_serial_module_events(sim), .i_supply_monitor_low(supply_monitor),
    .i_eeprom_write_end(ee), .i_async_serial_events(uart), .i_member_flags(mem),
    .i_stack_full(stk), .i_vector_ack(ack), .i_return_from_irq(ret),
    .o_irq_req(irq), .o_irq_vector(vec), .o_wake(wake));
  mist_core_model i_mist_core_model (.i_clk, .i_irq_req(irq), .i_irq_vector(vec),
    .i_use_return_from_irq(return_from_irq), .o_vector_ack(ack), .o_return_from_irq(ret), .o_taken(taken),
    .o_taken_vec(tvec));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  // a read notes its expectation and mask; the monitor compares at completion
  task automatic bus(input logic [7:0] ba, input logic w, input logic [31:0] d,
    input logic [31:0] m);
    @(posedge i_clk);
    addr <= ba[6:2];
    wr <= w;
    rd <= !w;
    wd <= d;
    if (!w) q.push_back({m, d & m});
    do @(posedge i_clk); while (wait_r);
    rd <= 0;
    wr <= 0;
  endtask
  task automatic wait_q;
    for (int n = 0; n < 3000 && vq.size() > 0; n++) @(posedge i_clk);
    chk("pending vectors", 0, vq.size());
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    logic [63:0] e;
    cyc++;
    sub <= (cyc % 8 == 0);
    if (cyc % 64 == 0) pull <= $random(seed);
    if (wake) nwake++;
    if (irq && !irq_d) begin
      t0 = t1;
      t1 = cyc;
      nrise++;
    end
    irq_d = irq;
    if (rd && !wait_r) begin
      e = q.pop_front();
      chk("readdata", e[31:0], rdata & e[63:32]);
    end
    if (taken && vq.size() > 0) chk("vector", vq.pop_front(), tvec);
  end
  initial begin
    #400us;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1;
    repeat (4) @(posedge i_clk);
    bus(8'h3C, 1, 32'hFF, 0);
    bus(8'h3C, 0, mist_pkg::UNMAPPED_RD, '1);
    for (int i = 0; i < 3; i++) begin
      a = 8'h10 + 8'(4 * i);
      bus(a, 0, 0, '1);
      r = $random(seed);
      bus(a, 1, r, 0);
      bus(a, 0, r & (i > 0 ? 32'h87 : 32'h3), '1);
      bus(a, 1, 0, 0);
    end
    bus(mist_pkg::ADDR_FLAGS, 1, '1, 0);
    w = nwake;
    for (int m = 0; m < 4; m++) begin
      bus(mist_pkg::ADDR_EDGE, 1, m, 0);
      for (int l = 1; l >= 0; l--) begin
        pins[0] <= l;
        repeat (3) @(posedge i_clk);
        bus(mist_pkg::ADDR_FLAGS, 0, (m == 3 || m == 2 - l), 1);
        bus(mist_pkg::ADDR_FLAGS, 1, '1, 0);
      end
    end
    chk("wakes", 4, nwake - w);
    bus(mist_pkg::ADDR_ENABLE, 1, 32'h7FFF, 0);
    vq = '{0, 2, 3, 4, 7, 8, 9, 10, 12};
    pins[0] <= 1;
    cmp <= 2'h3;
    cv <= 1;
    sim <= 4'(1 << ($unsigned($random(seed)) % 4));
    supply_monitor <= 1;
    ee <= 1;
    uart <= 6'(1 << ($unsigned($random(seed)) % 6));
    mem <= 4'h4;
    @(posedge i_clk);
    {cv, supply_monitor, ee, sim, uart} <= '0;
    bus(mist_pkg::ADDR_GLOBAL, 1, 1, 0);
    wait_q;
    bus(mist_pkg::ADDR_FLAGS, 0, 0, 32'h7FFF);
    bus(mist_pkg::ADDR_MEMBER, 0, 4, 32'hF);
    mem <= 0;
    stk <= 1;
    return_from_irq <= 0;
    cv <= 1;
    @(posedge i_clk);
    cv <= 0;
    repeat (10) @(posedge i_clk);
    chk("irq", 0, irq);
    vq.push_back(4);
    stk <= 0;
    wait_q;
    repeat (8) @(posedge i_clk);
    bus(mist_pkg::ADDR_GLOBAL, 0, 0, 1);
    ee <= 1;
    @(posedge i_clk);
    ee <= 0;
    repeat (4) @(posedge i_clk);
    bus(mist_pkg::ADDR_FLAGS, 0, 32'h200, 32'h7FFF);
    return_from_irq <= 1;
    vq.push_back(9);
    bus(mist_pkg::ADDR_GLOBAL, 1, 1, 0);
    wait_q;
    repeat (8) @(posedge i_clk);
    bus(mist_pkg::ADDR_GLOBAL, 0, 1, 1);
    bus(mist_pkg::ADDR_ENABLE, 1, 32'h60, 0);
    for (int k = 0; k < 4; k++) begin
      a = (k < 3) ? mist_pkg::ADDR_TB0 : mist_pkg::ADDR_TB1;
      bus(mist_pkg::ADDR_PSC, 1, ps[k], 0);
      bus(a, 1, (k < 3) ? 32'h80 : 32'h81, 0);
      w = nrise;
      // the first rise may come from a stale flag, so time the second gap
      for (int n = 0; n < 9000 && nrise < w + 3; n++) @(posedge i_clk);
      chk("period", per[k], t1 - t0);
      bus(a, 1, 0, 0);
      bus(mist_pkg::ADDR_FLAGS, 1, '1, 0);
    end
    wrap_up();
  end
endmodule
